// [esdop_pkg.sv]
// package: map, fields and states of the pwm
`default_nettype none
package esdop_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W       = 12;     // byte address width of the slave
    localparam int unsigned DATA_W       = 32;     // axi4-lite data width
    localparam int unsigned NUM_SLICES   = 8;      // slices 0 to 7
    localparam int unsigned CNT_W        = 24;     // period counter width
    localparam int unsigned DUTY_W       = 25;     // invert flag plus 24-bit high time

    // ----------------------------------------------------------------
    // global registers
    // ----------------------------------------------------------------
    localparam logic [11:0] CMD_OFS      = 12'h000; // write-only command word
    localparam logic [11:0] STATUS_OFS   = 12'h004; // slice run and wait flags
    localparam logic [3:0]  SLICE_PAGE   = 4'h1;    // addr[11:8] of slice pages
    localparam int unsigned SLICE_SHIFT  = 5;       // 0x20 bytes per slice
    // per-slice word index, addr[4:2]
    localparam logic [2:0]  PERIOD_IDX   = 3'h0;
    localparam logic [2:0]  DUTY_A_IDX   = 3'h1;
    localparam logic [2:0]  DUTY_B_IDX   = 3'h2;
    localparam logic [2:0]  CFG_IDX      = 3'h3;
    localparam logic [2:0]  OFFSET_IDX   = 3'h4;

    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int unsigned CMD_SYNC_BIT = 0;      // start/realign pulse
    localparam int unsigned CMD_STOP_LSB = 8;      // eight stop bits
    localparam int unsigned STAT_WAIT_LSB = 8;     // deferred slices
    localparam int unsigned DUTY_INV_BIT = 24;     // negative duty
    localparam int unsigned OFS_SKIP_BIT = 24;     // slice ignores sync
    localparam int unsigned CFG_EN_A     = 0;
    localparam int unsigned CFG_EN_B     = 1;
    localparam int unsigned CFG_CENTRE   = 2;
    localparam int unsigned CFG_DEFER    = 3;
    localparam int unsigned CFG_W        = 4;

    // ----------------------------------------------------------------
    // reset values and limits
    // ----------------------------------------------------------------
    localparam logic [23:0] PERIOD_RST   = 24'hffffff; // slowest rate
    localparam logic [23:0] PERIOD_MIN   = 24'h000004; // fastest rate is clock/4
    localparam logic [24:0] DUTY_RST     = 25'h0000000;
    localparam logic [3:0]  CFG_RST      = 4'h0;
    localparam logic [24:0] OFFSET_RST   = 25'h0000000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // slice states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,   // stopped, outputs low
        ST_WAIT = 3'b010,   // configured, waiting for a sync start
        ST_RUN  = 3'b100    // counting
    } esdop_state_t;
endpackage : esdop_pkg
`default_nettype wire

// [esdop_top.sv]
// eight-slice dual-output pwm generator with an axi4-lite register slave
`default_nettype none
module esdop_top
    import esdop_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [esdop_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [esdop_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [esdop_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [esdop_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [esdop_pkg::NUM_SLICES-1:0]   slice_output_first,
    output logic [esdop_pkg::NUM_SLICES-1:0]   slice_output_second
);
    import esdop_pkg::*;

    // ----------------------------------------------------------------
    // software-visible storage
    // ----------------------------------------------------------------
    logic [CNT_W-1:0]   period_ff [NUM_SLICES];   // period in clocks
    logic [DUTY_W-1:0]  duty_a_ff [NUM_SLICES];   // first_output_duty
    logic [DUTY_W-1:0]  duty_b_ff [NUM_SLICES];   // second_output_duty
    logic [CFG_W-1:0]   cfg_ff    [NUM_SLICES];   // enables, centre, defer
    logic [DUTY_W-1:0]  offset_ff [NUM_SLICES];   // sync offset, skip flag
    logic [NUM_SLICES-1:0] running;               // per-slice run state
    logic [NUM_SLICES-1:0] waiting;               // per-slice deferred state

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic              bvalid_ff;                 // response pending
    logic [1:0]        bresp_ff;                  // response code
    logic              wr_go;                     // address and data taken
    logic              wr_slice;                  // write hits a slice page
    logic [2:0]        wr_num;                    // slice number of write
    logic [2:0]        wr_idx;                    // word within slice page
    logic              wr_hit;                    // mapped write address
    logic [NUM_SLICES-1:0] launch_ff;             // cfg written last cycle
    logic              sync_ff;                   // sync pulse
    logic [NUM_SLICES-1:0] stop_ff;               // stop pulses

    // aw and w are taken together
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign wr_slice      = (s_axi_awaddr[11:8] == SLICE_PAGE) && (s_axi_awaddr[4:2] <= OFFSET_IDX);
    assign wr_num        = s_axi_awaddr[7:5];
    assign wr_idx        = s_axi_awaddr[4:2];
    assign wr_hit        = wr_slice || (s_axi_awaddr == CMD_OFS) || (s_axi_awaddr == STATUS_OFS);

    // byte-strobe merge
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // write response, held to bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;   // unmapped answers slverr
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // one-cycle command pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ff <= 1'b0;
            stop_ff <= '0;
        end else begin
            sync_ff <= wr_go && (s_axi_awaddr == CMD_OFS) && s_axi_wstrb[0] && s_axi_wdata[CMD_SYNC_BIT];
            stop_ff <= (wr_go && (s_axi_awaddr == CMD_OFS) && s_axi_wstrb[1])
                       ? s_axi_wdata[CMD_STOP_LSB +: NUM_SLICES] : '0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic              rvalid_ff;                 // read data pending
    logic [31:0]       rdata_ff;                  // read data
    logic [1:0]        rresp_ff;                  // read response
    logic [31:0]       rd_word;                   // decoded read word
    logic              rd_hit;                    // mapped read address

    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // read decode; the command word reads back as zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == CMD_OFS) begin
            rd_word = 32'h00000000;
        end else if (s_axi_araddr == STATUS_OFS) begin
            rd_word[NUM_SLICES-1:0]                 = running;
            rd_word[STAT_WAIT_LSB +: NUM_SLICES]    = waiting;
        end else if (s_axi_araddr[11:8] == SLICE_PAGE) begin
            case (s_axi_araddr[4:2])
                PERIOD_IDX: rd_word[CNT_W-1:0]  = period_ff[s_axi_araddr[7:5]];
                DUTY_A_IDX: rd_word[DUTY_W-1:0] = duty_a_ff[s_axi_araddr[7:5]];
                DUTY_B_IDX: rd_word[DUTY_W-1:0] = duty_b_ff[s_axi_araddr[7:5]];
                CFG_IDX:    rd_word[CFG_W-1:0]  = cfg_ff[s_axi_araddr[7:5]];
                OFFSET_IDX: rd_word[DUTY_W-1:0] = offset_ff[s_axi_araddr[7:5]];
                default:    rd_hit = 1'b0;
            endcase
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read answer a cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // slices
    // ----------------------------------------------------------------
    for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
        logic              wr_me;                 // write aimed at this slice
        esdop_state_t      state_ff;              // slice state
        logic [CNT_W-1:0]  cnt_ff;                // position within period
        logic [CNT_W-1:0]  sh_per_ff;             // active period
        logic [DUTY_W-1:0] sh_da_ff;              // active duty A
        logic [DUTY_W-1:0] sh_db_ff;              // active duty B
        logic [CFG_W-1:0]  sh_cfg_ff;             // active options
        logic [CNT_W-1:0]  per_clamp;             // period held at four or more
        logic              hi_a;                  // raw A level
        logic              hi_b;                  // raw B level
        logic              wrap;                  // last count of the period

        assign wr_me     = wr_go && wr_slice && (wr_num == 3'(s));
        assign per_clamp = (period_ff[s] < PERIOD_MIN) ? PERIOD_MIN : period_ff[s];
        assign wrap      = (cnt_ff >= sh_per_ff - 24'h000001);
        assign running[s] = (state_ff == ST_RUN);
        assign waiting[s] = (state_ff == ST_WAIT);

        // register writes, honouring byte strobes
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                period_ff[s] <= PERIOD_RST;
                duty_a_ff[s] <= DUTY_RST;
                duty_b_ff[s] <= DUTY_RST;
                cfg_ff[s]    <= CFG_RST;
                offset_ff[s] <= OFFSET_RST;
                launch_ff[s] <= 1'b0;
            end else begin
                launch_ff[s] <= wr_me && (wr_idx == CFG_IDX);
                if (wr_me) begin
                    case (wr_idx)
                        PERIOD_IDX: period_ff[s] <= CNT_W'(merge(32'(period_ff[s]), s_axi_wdata, s_axi_wstrb));
                        DUTY_A_IDX: duty_a_ff[s] <= DUTY_W'(merge(32'(duty_a_ff[s]), s_axi_wdata, s_axi_wstrb));
                        DUTY_B_IDX: duty_b_ff[s] <= DUTY_W'(merge(32'(duty_b_ff[s]), s_axi_wdata, s_axi_wstrb));
                        CFG_IDX:    cfg_ff[s]    <= CFG_W'(merge(32'(cfg_ff[s]), s_axi_wdata, s_axi_wstrb));
                        OFFSET_IDX: offset_ff[s] <= DUTY_W'(merge(32'(offset_ff[s]), s_axi_wdata, s_axi_wstrb));
                        default:    period_ff[s] <= period_ff[s];
                    endcase
                end
            end
        end

        // slice state and counter; stop beats launch beats sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                state_ff  <= ST_IDLE;
                cnt_ff    <= '0;
                sh_per_ff <= PERIOD_RST;
                sh_da_ff  <= DUTY_RST;
                sh_db_ff  <= DUTY_RST;
                sh_cfg_ff <= CFG_RST;
            end else if (stop_ff[s]) begin
                state_ff <= ST_IDLE;
                cnt_ff   <= '0;
            end else if (launch_ff[s]) begin
                // a cfg write relaunches
                state_ff  <= cfg_ff[s][CFG_DEFER] ? ST_WAIT : ST_RUN;
                cnt_ff    <= '0;
                sh_per_ff <= per_clamp;
                sh_da_ff  <= duty_a_ff[s];
                sh_db_ff  <= duty_b_ff[s];
                sh_cfg_ff <= cfg_ff[s];
            end else if (sync_ff && (state_ff != ST_IDLE) && !offset_ff[s][OFS_SKIP_BIT]) begin
                // launch or realign at the offset
                state_ff  <= ST_RUN;
                cnt_ff    <= (offset_ff[s][CNT_W-1:0] < per_clamp) ? offset_ff[s][CNT_W-1:0] : '0;
                sh_per_ff <= per_clamp;
                sh_da_ff  <= duty_a_ff[s];
                sh_db_ff  <= duty_b_ff[s];
                sh_cfg_ff <= cfg_ff[s];
            end else begin
                case (state_ff)
                    ST_RUN: begin
                        if (wrap) begin
                            // period and duty writes land at the boundary, so no runt pulse; a cfg write or a sync loads them at once
                            cnt_ff    <= '0;
                            sh_per_ff <= per_clamp;
                            sh_da_ff  <= duty_a_ff[s];
                            sh_db_ff  <= duty_b_ff[s];
                            sh_cfg_ff <= cfg_ff[s];
                        end else begin
                            cnt_ff <= cnt_ff + 24'h000001;
                        end
                    end
                    ST_WAIT: cnt_ff   <= '0;
                    ST_IDLE: cnt_ff   <= '0;
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end

        // level of one output at the current count
        function automatic logic level(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] per,
                                       input logic [CNT_W-1:0] high, input logic centre);
            logic [CNT_W:0] lo;
            lo = (high >= per) ? '0 : {1'b0, (per - high) >> 1};
            if (high >= per) begin
                return 1'b1;
            end else if (centre) begin
                // centred pulses share a midpoint regardless of width
                return ({1'b0, cnt} >= lo) && ({1'b0, cnt} < lo + {1'b0, high});
            end
            return cnt < high;
        endfunction

        assign hi_a = level(cnt_ff, sh_per_ff, sh_da_ff[CNT_W-1:0], sh_cfg_ff[CFG_CENTRE]);
        assign hi_b = level(cnt_ff, sh_per_ff, sh_db_ff[CNT_W-1:0], sh_cfg_ff[CFG_CENTRE]);

        // registered pins; stopped or disabled is low
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                slice_output_first[s]  <= 1'b0;
                slice_output_second[s] <= 1'b0;
            end else begin
                slice_output_first[s]  <= running[s] && sh_cfg_ff[CFG_EN_A]
                                          && (hi_a ^ sh_da_ff[DUTY_INV_BIT]);
                slice_output_second[s] <= running[s] && sh_cfg_ff[CFG_EN_B]
                                          && (hi_b ^ sh_db_ff[DUTY_INV_BIT]);
            end
        end
    end
endmodule // esdop_top
`default_nettype wire

// [esdop_load.sv]
// load model: high cycles and last rise per pin
`default_nettype none
module esdop_load (
    input  wire logic        aclk,
    input  wire logic        clr,
    input  wire logic [15:0] pins,
    output logic [15:0]      hi [16],
    output logic [31:0]      rise [16]
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // pin observation
    // ----------------------------------------------------------------
    logic [31:0] now_ff  = 32'h0;   // cycle count
    logic [15:0] prev_ff = 16'h0;   // pin levels one edge ago
    // the load only listens
    always @(posedge aclk) begin
        now_ff  <= now_ff + 32'h1;
        prev_ff <= pins;
        for (int i = 0; i < 16; i++) begin
            hi[i] <= clr ? 16'h0 : hi[i] + 16'(pins[i]);
            if (pins[i] && !prev_ff[i]) begin
                rise[i] <= now_ff;  // only differences matter
            end
        end
    end
endmodule // esdop_load
`default_nettype wire

// [esdop_chk.sv]
// checker: bus and output assertions of the pwm
`default_nettype none
module esdop_chk
    import esdop_pkg::*;
(
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire logic [esdop_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input wire logic                          s_axi_awvalid,
    input wire logic                          s_axi_awready,
    input wire logic [esdop_pkg::DATA_W-1:0]  s_axi_wdata,
    input wire logic [3:0]                    s_axi_wstrb,
    input wire logic                          s_axi_wvalid,
    input wire logic                          s_axi_wready,
    input wire logic [1:0]                    s_axi_bresp,
    input wire logic                          s_axi_bvalid,
    input wire logic                          s_axi_bready,
    input wire logic [esdop_pkg::ADDR_W-1:0]  s_axi_araddr,
    input wire logic                          s_axi_arvalid,
    input wire logic                          s_axi_arready,
    input wire logic [esdop_pkg::DATA_W-1:0]  s_axi_rdata,
    input wire logic [1:0]                    s_axi_rresp,
    input wire logic                          s_axi_rvalid,
    input wire logic                          s_axi_rready,
    input wire logic [esdop_pkg::NUM_SLICES-1:0] slice_output_first,
    input wire logic [esdop_pkg::NUM_SLICES-1:0] slice_output_second
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // helper terms
    // ----------------------------------------------------------------
    logic wr_go;    // write taken
    logic rd_go;    // read taken
    logic cfg_hit;  // write to a config word
    assign wr_go   = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    assign rd_go   = s_axi_arvalid && s_axi_arready;
    assign cfg_hit = wr_go && s_axi_awaddr[11:8] == SLICE_PAGE && s_axi_awaddr[4:2] == CFG_IDX && s_axi_wstrb[0];
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("write not answered");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_resp_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (rd_go |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
        else $error("read data not held");
    a_ready_pair: assert property (s_axi_awready == s_axi_wready && !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
        else $error("ready taken while busy");
    a_cmd_reads_zero: assert property (rd_go && s_axi_araddr == CMD_OFS |=> s_axi_rdata == 32'h0)
        else $error("command word read nonzero");
    a_stop_quiet: assert property (wr_go && s_axi_awaddr == CMD_OFS && s_axi_wstrb[1] |->
        ##3 ((slice_output_first | slice_output_second) & $past(s_axi_wdata[15:8], 3)) == 8'h0)
        else $error("stopped slice still drives");
    a_cfg_quiet: assert property (cfg_hit |-> ##3
        !(slice_output_first[$past(s_axi_awaddr[7:5], 3)] && ($past(s_axi_wdata[CFG_DEFER], 3) || !$past(s_axi_wdata[CFG_EN_A], 3)))
        && !(slice_output_second[$past(s_axi_awaddr[7:5], 3)] && ($past(s_axi_wdata[CFG_DEFER], 3) || !$past(s_axi_wdata[CFG_EN_B], 3))))
        else $error("disabled or deferred output drives");
    a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> slice_output_first == 8'h0
        && slice_output_second == 8'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy after reset");
endmodule // esdop_chk
bind esdop_top esdop_chk u_chk (.*);
`default_nettype wire

// [esdop_bench.sv]
// testbench of the eight-slice pwm
`default_nettype none
module esdop_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import esdop_pkg::*;
    // ----------------------------------------------------------------
    // signals, queues and counters
    // ----------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  out_a, out_b;
    logic [15:0] hi [16];                        // high cycles per pin
    logic [31:0] rise [16];                      // last rising edge per pin
    logic [33:0] bq [$], rq [$];                 // expected answers, oldest first
    int          error_cnt = 0, n_compared = 0, r2;
    integer      seed = 32'h63f0;
    int          da [8], db [8];
    int          per [8] = '{4, 10, 12, 14, 16, 20, 24, 28};  // every period divides the 1680 window
    always #10 aclk = ~aclk;
    esdop_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .slice_output_first(out_a), .slice_output_second(out_b));
    esdop_load u_load (.aclk(aclk), .clr(clr), .pins({out_b, out_a}), .hi(hi), .rise(rise));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bounded wait, judged mid-cycle
    task automatic wt(input int k);
        for (int i = 0; i < 200; i++) begin
            @(negedge aclk);
            if ((k == 0 && awready) || (k == 1 && bvalid) || (k == 2 && arready) || (k == 3 && rvalid)) return;
        end
        cmp(34'h0, 34'h1);
        end_sim();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({32'h0, r});
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
        wt(0);
        @(posedge aclk);
        {awvalid, wvalid} <= 2'b00;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);  // random stall on the response
        bready  <= 1'b1;
        wt(1);
        @(posedge aclk);
        bready  <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        wt(2);
        @(posedge aclk);
        arvalid <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        rready  <= 1'b1;
        wt(3);
        @(posedge aclk);
        rready  <= 1'b0;
    endtask
    // clear, then count w edges
    task automatic meas(input int w);
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (w) @(posedge aclk);
        @(negedge aclk);
    endtask
    function automatic logic [11:0] sa(input int n, input int idx);
        return 12'h100 + 12'(n * 32 + idx * 4);
    endfunction
    // high cycles in 1680; duty >= period saturates
    function automatic int ex(input int p, input int d, input bit inv, input bit en);
        int h;
        h = (d >= p) ? p : d;
        if (inv) h = p - h;
        return en ? h * 1680 / p : 0;
    endfunction
    // ----------------------------------------------------------------
    // response watcher, oldest note first
    // ----------------------------------------------------------------
    always @(negedge aclk) begin
        if (bvalid && bready && bq.size() > 0) cmp({32'h0, bresp}, bq.pop_front());
        if (rvalid && rready && rq.size() > 0) cmp({rresp, rdata}, rq.pop_front());
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sa(3, PERIOD_IDX), 32'h00ffffff, RESP_OKAY);
        rd(sa(3, CFG_IDX), 32'h0, RESP_OKAY);
        rd(STATUS_OFS, 32'h0, RESP_OKAY);
        rd(sa(5, 5), 32'h0, RESP_SLVERR);
        wr(sa(5, 7), 32'h1, RESP_SLVERR);
        wr(STATUS_OFS, 32'hff, RESP_OKAY);
        rd(CMD_OFS, 32'h0, RESP_OKAY);
        // random duties, own periods and options
        for (int n = 0; n < 8; n++) begin
            da[n] = $unsigned($random(seed)) % per[n];
            db[n] = $unsigned($random(seed)) % (per[n] + 2);
            wr(sa(n, PERIOD_IDX), 32'(per[n]), RESP_OKAY);
            wr(sa(n, DUTY_A_IDX), {7'h0, n[1], 24'(da[n])}, RESP_OKAY);
            wr(sa(n, DUTY_B_IDX), {7'h0, ~n[0], 24'(db[n])}, RESP_OKAY);
            wr(sa(n, CFG_IDX), {28'h0, 1'b0, n[0], n != 7, 1'b1}, RESP_OKAY);
        end
        rd(STATUS_OFS, 32'h000000ff, RESP_OKAY);
        meas(1680);
        for (int n = 0; n < 8; n++) begin
            cmp(34'(hi[n]), 34'(ex(per[n], da[n], n[1], 1'b1)));
            cmp(34'(hi[n + 8]), 34'(ex(per[n], db[n], ~n[0], n != 7)));
        end
        // defer 0, retune 1, exclude 2 from sync
        wr(sa(0, PERIOD_IDX), 32'h8, RESP_OKAY);
        wr(sa(0, DUTY_A_IDX), 32'h4, RESP_OKAY);
        wr(sa(0, CFG_IDX), 32'h9, RESP_OKAY);
        wr(sa(1, PERIOD_IDX), 32'h8, RESP_OKAY);
        wr(sa(1, DUTY_A_IDX), 32'h4, RESP_OKAY);
        wr(sa(1, OFFSET_IDX), 32'h3, RESP_OKAY);
        wr(sa(2, DUTY_A_IDX), 32'h01000006, RESP_OKAY);
        wr(sa(2, OFFSET_IDX), 32'h01000000, RESP_OKAY);
        meas(40);
        cmp(34'(hi[0]), 34'h0);
        rd(STATUS_OFS, 32'h000001fe, RESP_OKAY);
        r2 = rise[2];
        wr(CMD_OFS, 32'h1, RESP_OKAY);
        meas(48);
        cmp(34'((rise[1] - rise[0]) % 8), 34'h7);
        cmp(34'((rise[2] - r2) % 12), 34'h0);
        cmp(34'(hi[0]), 34'd24);
        cmp(34'(hi[1]), 34'd24);
        rd(STATUS_OFS, 32'h000000ff, RESP_OKAY);
        // stop one slice, then a sync that must not revive it
        wr(CMD_OFS, 32'h00000800, RESP_OKAY);
        wr(CMD_OFS, 32'h1, RESP_OKAY);
        meas(48);
        cmp(34'(hi[3]), 34'h0);
        cmp(34'(hi[11]), 34'h0);
        cmp(34'(hi[0]), 34'd24);
        rd(STATUS_OFS, 32'h000000f7, RESP_OKAY);
        end_sim();
    end
endmodule // esdop_bench
`default_nettype wire
